// ### core/rvc_params.svh
`ifndef RVC_PARAMS_SVH
`define RVC_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RVC_OFS_CONV4_SLEEP  8'h95
`define RVC_OFS_CONV5_NORMAL 8'h96
`define RVC_OFS_CONV5_SLEEP  8'h97
`define RVC_OFS_CONV6_NORMAL 8'h98
`define RVC_OFS_CONV6_SLEEP  8'h99
`define RVC_OFS_LINEAR2      8'h9a
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RVC_CODE_MSB     7
`define RVC_CODE_LSB     1
`define RVC_FALL_BIT     0
`define RVC_LIN_SLP_MSB  7
`define RVC_LIN_SLP_LSB  4
`define RVC_LIN_NRM_MSB  3
`define RVC_LIN_NRM_LSB  0
// ----------------------------------------
// Sleep vector lanes
// ----------------------------------------
`define RVC_LANE_CONV4   0
`define RVC_LANE_CONV5   1
`define RVC_LANE_CONV6   2
`define RVC_LANE_LINEAR2 3
// ----------------------------------------
// Factory default patterns
// ----------------------------------------
`define RVC_RST_CONV4_SLEEP  8'ha8
`define RVC_RST_CONV5_NORMAL 8'he8
`define RVC_RST_CONV5_SLEEP  8'he8
`define RVC_RST_CONV6_NORMAL 8'h58
`define RVC_RST_CONV6_SLEEP  8'h4c
`define RVC_RST_LINEAR2      8'h00
`define RVC_READ_ZERO        8'h00
`endif

// ### core/rvc_pkg.sv
package rvc_pkg;
    // ----------------------------------------
    // Register access request
    // ----------------------------------------
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle
        logic       rd;    // Read strobe, one cycle
        logic [7:0] addr;  // Register offset
        logic [7:0] wdata; // Write data
    } rvc_req_t;
    // ----------------------------------------
    // Read answer
    // ----------------------------------------
    typedef struct packed {
        logic       valid; // One-cycle answer marker
        logic [7:0] data;  // Read data
    } rvc_rsp_t;
endpackage : rvc_pkg

// ### core/rvc_regs.sv
// Overview of operation
// - Converter 4 sleep code in 95h bits 7:1
// - Converter 5 normal code in 96h bits 7:1
// - Converter 5 sleep code in 97h bits 7:1
// - Converter 6 normal code in 98h bits 7:1
// - Converter 6 sleep code in 99h bits 7:1
// - Bit 0 of 96h and 98h chooses slewed or passive fall
// - Code step range fixed by configuration
// - Linear 2 sleep code in 9Ah bits 7:4
// - Linear 2 normal code in 9Ah bits 3:0
// - Sleep code applied when enabled, pin low
`timescale 1ns/1ns
`include "rvc_params.svh"

module rvc_regs #(
    parameter logic [7:0] RST_CONV4_SLEEP  = `RVC_RST_CONV4_SLEEP,  // Variant default
    parameter logic [7:0] RST_CONV5_NORMAL = `RVC_RST_CONV5_NORMAL, // Variant default
    parameter logic [7:0] RST_CONV5_SLEEP  = `RVC_RST_CONV5_SLEEP,  // Variant default
    parameter logic [7:0] RST_CONV6_NORMAL = `RVC_RST_CONV6_NORMAL, // Variant default
    parameter logic [7:0] RST_CONV6_SLEEP  = `RVC_RST_CONV6_SLEEP,  // Variant default
    parameter logic [7:0] RST_LINEAR2      = `RVC_RST_LINEAR2,      // Variant default
    parameter logic       STEP_25MV        = 1'b0                   // 0: 10 mV steps, 1: 25 mV
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire rvc_pkg::rvc_req_t req,
    output rvc_pkg::rvc_rsp_t     rsp,
    input  wire logic [6:0]       conv4_normal_code,
    input  wire logic [3:0]       sleep_en,
    input  wire logic [3:0]       sleep_pin,
    output logic [6:0]            conv4_ref_code,
    output logic [6:0]            conv5_ref_code,
    output logic [6:0]            conv6_ref_code,
    output logic [3:0]            linear2_ref_code,
    output logic                  conv5_passive_fall_sel,
    output logic                  conv6_passive_fall_sel,
    output logic                  step_25mv_sel
);

    // ----------------------------------------
    // Assertion clocking
    // ----------------------------------------
    // All checks below share the one clock and are silenced during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [6:0] conv4_sleep_code_reg;  // Sleep code, converter 4
    logic [6:0] conv5_normal_code_reg; // Normal code, converter 5
    logic [6:0] conv5_sleep_code_reg;  // Sleep code, converter 5
    logic [6:0] conv6_normal_code_reg; // Normal code, converter 6
    logic [6:0] conv6_sleep_code_reg;  // Sleep code, converter 6
    logic [3:0] linear2_sleep_code_reg;  // Sleep code, linear 2
    logic [3:0] linear2_normal_code_reg; // Normal code, linear 2
    logic [7:0] rd_data_next;            // Read mux output

    // Write hit for one offset
    function automatic logic hit(input rvc_pkg::rvc_req_t r, input logic [7:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction : hit

    // Pick the sleep or normal code; sleep pin is active low
    function automatic logic [6:0] pick(input logic en, input logic pin,
                                        input logic [6:0] slp, input logic [6:0] nrm);
        pick = (en && !pin) ? slp : nrm;
    endfunction : pick

    // ----------------------------------------
    // Converter 4 sleep register
    // ----------------------------------------
    // Reserved bit 0 is never stored, so writes to it vanish
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv4_sleep_code_reg <= RST_CONV4_SLEEP[`RVC_CODE_MSB:`RVC_CODE_LSB];
        end else if (hit(req, `RVC_OFS_CONV4_SLEEP)) begin
            conv4_sleep_code_reg <= req.wdata[`RVC_CODE_MSB:`RVC_CODE_LSB];
        end
    end

    // ----------------------------------------
    // Converter 5 registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv5_normal_code_reg  <= RST_CONV5_NORMAL[`RVC_CODE_MSB:`RVC_CODE_LSB];
            conv5_passive_fall_sel <= RST_CONV5_NORMAL[`RVC_FALL_BIT];
            conv5_sleep_code_reg   <= RST_CONV5_SLEEP[`RVC_CODE_MSB:`RVC_CODE_LSB];
        end else begin
            // Normal code and fall mode share one write
            if (hit(req, `RVC_OFS_CONV5_NORMAL)) begin
                conv5_normal_code_reg  <= req.wdata[`RVC_CODE_MSB:`RVC_CODE_LSB];
                conv5_passive_fall_sel <= req.wdata[`RVC_FALL_BIT];
            end
            // Sleep code; bit 0 reserved
            if (hit(req, `RVC_OFS_CONV5_SLEEP)) begin
                conv5_sleep_code_reg <= req.wdata[`RVC_CODE_MSB:`RVC_CODE_LSB];
            end
        end
    end

    // ----------------------------------------
    // Converter 6 registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv6_normal_code_reg  <= RST_CONV6_NORMAL[`RVC_CODE_MSB:`RVC_CODE_LSB];
            conv6_passive_fall_sel <= RST_CONV6_NORMAL[`RVC_FALL_BIT];
            conv6_sleep_code_reg   <= RST_CONV6_SLEEP[`RVC_CODE_MSB:`RVC_CODE_LSB];
        end else begin
            // Normal code and fall mode share one write
            if (hit(req, `RVC_OFS_CONV6_NORMAL)) begin
                conv6_normal_code_reg  <= req.wdata[`RVC_CODE_MSB:`RVC_CODE_LSB];
                conv6_passive_fall_sel <= req.wdata[`RVC_FALL_BIT];
            end
            // Sleep code; bit 0 reserved
            if (hit(req, `RVC_OFS_CONV6_SLEEP)) begin
                conv6_sleep_code_reg <= req.wdata[`RVC_CODE_MSB:`RVC_CODE_LSB];
            end
        end
    end

    // ----------------------------------------
    // Linear regulator 2 register
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            linear2_sleep_code_reg  <= RST_LINEAR2[`RVC_LIN_SLP_MSB:`RVC_LIN_SLP_LSB];
            linear2_normal_code_reg <= RST_LINEAR2[`RVC_LIN_NRM_MSB:`RVC_LIN_NRM_LSB];
        end else if (hit(req, `RVC_OFS_LINEAR2)) begin
            linear2_sleep_code_reg  <= req.wdata[`RVC_LIN_SLP_MSB:`RVC_LIN_SLP_LSB];
            linear2_normal_code_reg <= req.wdata[`RVC_LIN_NRM_MSB:`RVC_LIN_NRM_LSB];
        end
    end

    // ----------------------------------------
    // Step range
    // ----------------------------------------
    // Fixed by variant; software cannot alter how codes are scaled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_25mv_sel <= STEP_25MV;
        end else begin
            step_25mv_sel <= STEP_25MV;
        end
    end

    // ----------------------------------------
    // Reference selection
    // ----------------------------------------
    // Re-evaluated every cycle, so a write lands with no extra command;
    // the cost is one flop of latency behind the register itself
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv4_ref_code   <= 7'h00;
            conv5_ref_code   <= 7'h00;
            conv6_ref_code   <= 7'h00;
            linear2_ref_code <= 4'h0;
        end else begin
            conv4_ref_code <= pick(sleep_en[`RVC_LANE_CONV4], sleep_pin[`RVC_LANE_CONV4],
                                   conv4_sleep_code_reg, conv4_normal_code);
            conv5_ref_code <= pick(sleep_en[`RVC_LANE_CONV5], sleep_pin[`RVC_LANE_CONV5],
                                   conv5_sleep_code_reg, conv5_normal_code_reg);
            conv6_ref_code <= pick(sleep_en[`RVC_LANE_CONV6], sleep_pin[`RVC_LANE_CONV6],
                                   conv6_sleep_code_reg, conv6_normal_code_reg);
            // Linear codes are four bits wide, so selected inline
            if (sleep_en[`RVC_LANE_LINEAR2] && !sleep_pin[`RVC_LANE_LINEAR2]) begin
                linear2_ref_code <= linear2_sleep_code_reg;
            end else begin
                linear2_ref_code <= linear2_normal_code_reg;
            end
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Reserved bits and unmapped offsets read as zero
    always_comb begin
        case (req.addr)
            `RVC_OFS_CONV4_SLEEP:  begin
                rd_data_next = {conv4_sleep_code_reg, 1'b0};
            end
            `RVC_OFS_CONV5_NORMAL: begin
                rd_data_next = {conv5_normal_code_reg, conv5_passive_fall_sel};
            end
            `RVC_OFS_CONV5_SLEEP:  begin
                rd_data_next = {conv5_sleep_code_reg, 1'b0};
            end
            `RVC_OFS_CONV6_NORMAL: begin
                rd_data_next = {conv6_normal_code_reg, conv6_passive_fall_sel};
            end
            `RVC_OFS_CONV6_SLEEP:  begin
                rd_data_next = {conv6_sleep_code_reg, 1'b0};
            end
            `RVC_OFS_LINEAR2:      begin
                rd_data_next = {linear2_sleep_code_reg, linear2_normal_code_reg};
            end
            default: begin
                rd_data_next = `RVC_READ_ZERO;
            end
        endcase
    end

    // ----------------------------------------
    // Read answer
    // ----------------------------------------
    // Data holds until the next read so a slow serial engine can fetch it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.rd;
            if (req.rd) begin
                rsp.data <= rd_data_next;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------

    property p_conv4_sleep_wr;
        hit(req, `RVC_OFS_CONV4_SLEEP) |=> conv4_sleep_code_reg == $past(req.wdata[7:1]);
    endproperty
    a_conv4_sleep_wr: assert property (p_conv4_sleep_wr) else $error("conv4 sleep write lost");

    // A read right behind a write must already see the new byte
    property p_conv5_normal_wr;
        hit(req, `RVC_OFS_CONV5_NORMAL) ##1 req.rd && req.addr == `RVC_OFS_CONV5_NORMAL
            |=> rsp.valid && rsp.data == $past(req.wdata, 2);
    endproperty
    a_conv5_normal_wr: assert property (p_conv5_normal_wr) else $error("conv5 normal readback wrong");

    property p_conv5_sleep_rd;
        hit(req, `RVC_OFS_CONV5_SLEEP) ##1 req.rd && req.addr == `RVC_OFS_CONV5_SLEEP
            |=> rsp.data == {$past(req.wdata[7:1], 2), 1'b0};
    endproperty
    a_conv5_sleep_rd: assert property (p_conv5_sleep_rd) else $error("conv5 sleep readback wrong");

    // Only a write hit may move the stored code
    property p_conv6_normal_hold;
        !hit(req, `RVC_OFS_CONV6_NORMAL) |=> $stable(conv6_normal_code_reg);
    endproperty
    a_conv6_normal_hold: assert property (p_conv6_normal_hold) else $error("conv6 normal changed");

    property p_conv6_sleep_rsvd;
        req.rd && req.addr == `RVC_OFS_CONV6_SLEEP |=> rsp.data[0] == 1'b0;
    endproperty
    a_conv6_sleep_rsvd: assert property (p_conv6_sleep_rsvd) else $error("reserved bit nonzero");

    property p_fall_sel;
        hit(req, `RVC_OFS_CONV5_NORMAL) |=> conv5_passive_fall_sel == $past(req.wdata[0]);
    endproperty
    a_fall_sel: assert property (p_fall_sel) else $error("fall select not stored");

    // Guards the range flop against later edits that make it writable
    property p_step_fixed;
        step_25mv_sel == STEP_25MV;
    endproperty
    a_step_fixed: assert property (p_step_fixed) else $error("step range moved");

    property p_linear2_wr;
        hit(req, `RVC_OFS_LINEAR2) |=> linear2_sleep_code_reg == $past(req.wdata[7:4])
            && linear2_normal_code_reg == $past(req.wdata[3:0]);
    endproperty
    a_linear2_wr: assert property (p_linear2_wr) else $error("linear2 fields wrong");

    // The edge that releases reset still leaves the reference at zero, so skip it
    property p_sleep_apply;
        arst_n && sleep_en[1] && !sleep_pin[1] |=> conv5_ref_code == $past(conv5_sleep_code_reg);
    endproperty
    a_sleep_apply: assert property (p_sleep_apply) else $error("sleep code not applied");

    // Offsets outside the window must never leak stale data
    property p_unmapped_zero;
        req.rd && !(req.addr inside {[8'h95:8'h9a]}) |=> rsp.data == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

    // Two edges from strobe to reference when the lane stays awake
    property p_write_effect;
        hit(req, `RVC_OFS_CONV6_NORMAL) && !sleep_en[2] ##1 !sleep_en[2]
            |=> conv6_ref_code == $past(req.wdata[7:1], 2);
    endproperty
    a_write_effect: assert property (p_write_effect) else $error("write did not reach reference");

    // Every read is answered exactly one edge later, and nothing else is
    property p_rd_answer;
        rsp.valid == $past(req.rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer marker wrong");

    // Main scenarios the bench is expected to reach
    c_sleep_entry: cover property (sleep_en[0] && !sleep_pin[0] ##1 conv4_ref_code == conv4_sleep_code_reg);
    c_linear2_wr:  cover property (hit(req, `RVC_OFS_LINEAR2) ##2 linear2_ref_code != 4'h0);
    c_read_back:   cover property (req.rd && req.addr == `RVC_OFS_CONV4_SLEEP ##1 rsp.valid);
    c_fall_set:    cover property (hit(req, `RVC_OFS_CONV6_NORMAL) && req.wdata[0]);
    c_back_read:   cover property (hit(req, `RVC_OFS_CONV5_NORMAL) ##1 req.rd && req.addr == `RVC_OFS_CONV5_NORMAL);

endmodule : rvc_regs

// ### dv/rvc_regs_tb.sv
`timescale 1ns/1ns
`include "rvc_params.svh"

module rvc_regs_tb;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic              clk;                    // 10 MHz bench clock
    logic              arst_n;                 // Active-low reset
    rvc_pkg::rvc_req_t req;                    // Register request
    rvc_pkg::rvc_rsp_t rsp;                    // Read answer
    logic [6:0]        conv4_normal_code;      // Converter 4 normal code input
    logic [3:0]        sleep_en;               // Sleep enable per lane
    logic [3:0]        sleep_pin;              // Sleep pin level per lane
    logic [6:0]        conv4_ref_code;         // Applied codes
    logic [6:0]        conv5_ref_code;
    logic [6:0]        conv6_ref_code;
    logic [3:0]        linear2_ref_code;
    logic              conv5_passive_fall_sel; // Fall style selects
    logic              conv6_passive_fall_sel;
    logic              step_25mv_sel;          // Step range flag
    integer            n_errors;               // Mismatch count
    integer            checks_done;            // Comparison count
    integer            seed;                   // Random seed
    integer            cycles;                 // Timeout counter
    integer            k;                      // Loop index
    logic [7:0]        a;                      // Scratch address
    integer            model [0:5];            // Reference copy of the six registers

    rvc_regs DUT (
        .clk                    (clk),
        .arst_n                 (arst_n),
        .req                    (req),
        .rsp                    (rsp),
        .conv4_normal_code      (conv4_normal_code),
        .sleep_en               (sleep_en),
        .sleep_pin              (sleep_pin),
        .conv4_ref_code         (conv4_ref_code),
        .conv5_ref_code         (conv5_ref_code),
        .conv6_ref_code         (conv6_ref_code),
        .linear2_ref_code       (linear2_ref_code),
        .conv5_passive_fall_sel (conv5_passive_fall_sel),
        .conv6_passive_fall_sel (conv6_passive_fall_sel),
        .step_25mv_sel          (step_25mv_sel)
    );

    // ----------------------------------------
    // Clock and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Ceiling well above the roughly 1000 cycles the sequence needs
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Writable bits per offset; zero means unmapped
    function automatic logic [7:0] wmask(input logic [7:0] adr);
        case (adr)
            8'h95, 8'h97, 8'h99: wmask = 8'hfe;
            8'h96, 8'h98, 8'h9a: wmask = 8'hff;
            default:             wmask = 8'h00;
        endcase
    endfunction : wmask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Factory patterns, reserved bits cleared since they read zero
    task automatic init_model;
        model[0] = `RVC_RST_CONV4_SLEEP & 8'hfe;
        model[1] = `RVC_RST_CONV5_NORMAL;
        model[2] = `RVC_RST_CONV5_SLEEP & 8'hfe;
        model[3] = `RVC_RST_CONV6_NORMAL;
        model[4] = `RVC_RST_CONV6_SLEEP & 8'hfe;
        model[5] = `RVC_RST_LINEAR2;
    endtask : init_model

    // One access; a read in the same cycle as a write expects the old value
    task automatic access(input logic w, input logic r, input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] exp;
        exp = (wmask(adr) != 8'h00) ? model[adr - 8'h95] : 8'h00;
        @(posedge clk);
        req.wr    <= w;
        req.rd    <= r;
        req.addr  <= adr;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        if (w && wmask(adr) != 8'h00) begin
            model[adr - 8'h95] = d & wmask(adr);
        end
        #1;
        if (r) begin
            chk({7'h00, rsp.valid}, 8'h01);
            chk(rsp.data, exp);
        end
        // Answer marker must last exactly one cycle
        @(posedge clk);
        #1;
        chk({7'h00, rsp.valid}, 8'h00);
    endtask : access

    // Write then read the same offset on the very next edge, as a fast host would
    task automatic wr_rd(input logic [7:0] adr, input logic [7:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.rd    <= 1'b0;
        req.addr  <= adr;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b1;
        model[adr - 8'h95] = d & wmask(adr);
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk({7'h00, rsp.valid}, 8'h01);
        chk(rsp.data, model[adr - 8'h95]);
    endtask : wr_rd

    // Sleep code wins only where the lane is enabled and its pin is low
    task automatic check_refs;
        logic [3:0] slp;
        repeat (2) @(posedge clk);
        #1;
        slp = sleep_en & ~sleep_pin;
        chk({1'b0, conv4_ref_code}, slp[0] ? {1'b0, model[0][7:1]} : {1'b0, conv4_normal_code});
        chk({1'b0, conv5_ref_code}, slp[1] ? {1'b0, model[2][7:1]} : {1'b0, model[1][7:1]});
        chk({1'b0, conv6_ref_code}, slp[2] ? {1'b0, model[4][7:1]} : {1'b0, model[3][7:1]});
        chk({4'h0, linear2_ref_code}, slp[3] ? {4'h0, model[5][7:4]} : {4'h0, model[5][3:0]});
        chk({7'h00, conv5_passive_fall_sel}, {7'h00, model[1][0]});
        chk({7'h00, conv6_passive_fall_sel}, {7'h00, model[3][0]});
        chk({7'h00, step_25mv_sel}, 8'h00);
    endtask : check_refs

    // Reads the mapped window plus one unmapped offset on each side
    task automatic read_all;
        logic [7:0] adr;
        for (adr = 8'h94; adr <= 8'h9b; adr = adr + 8'h01) begin
            access(1'b0, 1'b1, adr, 8'h00);
        end
    endtask : read_all

    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_errors          = 0;
        checks_done       = 0;
        cycles            = 0;
        seed              = 31;
        arst_n            = 1'b0;
        req               = '0;
        conv4_normal_code = 7'h00;
        sleep_en          = 4'h0;
        sleep_pin         = 4'hf;
        init_model();
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        read_all();
        check_refs();
        // Random writes over mapped and unmapped offsets, some with a read alongside
        for (k = 0; k < 80; k = k + 1) begin
            a = 8'h94 + ($random(seed) & 7);
            access(1'b1, k[0], a, $random(seed));
            access(1'b0, 1'b1, a, 8'h00);
            wr_rd(`RVC_OFS_CONV5_NORMAL + {7'h00, k[0]}, $random(seed));
            @(posedge clk);
            sleep_en          <= $random(seed);
            sleep_pin         <= $random(seed);
            conv4_normal_code <= $random(seed);
            check_refs();
        end
        // Reset in mid-run restores the factory patterns
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        init_model();
        read_all();
        check_refs();
        report_and_stop();
    end
endmodule : rvc_regs_tb
